// [ssc_regs.vh]
// Register map, field positions, reset values and cycle counts of the reset sequencer
`ifndef SSC_REGS_VH
`define SSC_REGS_VH
`define SSC_CFG_OFS        12'h000
`define SSC_CAUSE_OFS      12'h004
`define SSC_STAT_OFS       12'h008
`define SSC_CFG_PINEN      0
`define SSC_CFG_SHORT_STOP_RECOVERY      1
`define SSC_CFG_WAITPER    2
`define SSC_CFG_RST        3'h0
`define SSC_CAUSE_POR      0
`define SSC_CAUSE_PIN      1
`define SSC_CAUSE_WDOG     2
`define SSC_CAUSE_ILOP     3
`define SSC_CAUSE_ILAD     4
`define SSC_CAUSE_BROWN    5
`define SSC_CAUSE_RST      6'h01
`define SSC_POR_CYC        13'h1000
`define SSC_LONG_STOP_CYC  13'h1000
`define SSC_SHORT_STOP_CYC 13'h0020
`define SSC_DRIVE_CYC      6'h20
`define SSC_HOLD_CYC       6'h20
`define SSC_VEC_CYC        6'h03
`define SSC_PIN_MIN_CYC    6'h04
`define SSC_VEC_USER       16'hFFFE
`define SSC_VEC_MON        16'hFEFE
`endif

// [ssc_top.v]
// Reset, clock-gating and reset-cause logic of the system integration block
`timescale 1ns/10ps
// Summary of operation
// - Bus clock is the fast clock divided by two, then by two again.
// - After power-on, CPU and peripheral clocks stay off for 4160 cycles: 4096 counted, then 32 drive and 32 hold.
// - Stop exit counts fast clocks; clocks stay off for 4096 or 32 cycles.
// - Wait mode stops CPU clock; peripheral clock runs if configured active.
// - Every reset source asserts internal reset and fetches the reset vector pair.
// - Internal reset returns the config register to its default value; cause flags are kept.
// - Internal reset clears the cycle counter; external pin reset does not.
// - Each reset sets the cause flag of the source that produced it.
// - Reset pin held low by outside party halts all processing.
// - Outside party holds pin low for minimum time; then pin cause flag sets.
// - Reset pin acts as port input at all times; it also acts as reset input once the pin enable bit is set.
// - Power-on and brownout count 4096 cycles, then run the common sequence.
// - Internal resets drive the reset pin low for 32 cycles.
// - Internal reset stays asserted 32 further cycles after pin release.
// - Recovery lasts 4163 cycles for power-on and brownout, 67 for internal sources, 35 after pin release.
// - Watchdog reset request is accepted asynchronously to the bus clock.
// - Cycle counter advances on falling fast-clock edge, twelve stages plus a thirteenth.
// - Short stop recovery bit cuts stop delay from 4096 to 32 cycles.
// - Illegal-address reset only for opcode fetch from unmapped address.
`include "ssc_regs.vh"
module ssc_top (
	input  wire        sys_clk,
	input  wire        rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        reset_pin_in,
	output reg         reset_pin_out,
	output reg         reset_pin_oe,
	output reg         port_a_bit_three,
	input  wire        watchdog_req,
	input  wire        brownout_detect,
	input  wire        illegal_opcode,
	input  wire        opcode_fetch,
	input  wire        unmapped_addr,
	input  wire        monitor_mode,
	input  wire        stop_req,
	input  wire        wait_req,
	input  wire        wake_event,
	output reg         internal_reset,
	output reg         half_source_clock,
	output reg         cpu_bus_clk,
	output reg         periph_bus_clk,
	output reg  [15:0] vector_addr,
	output reg         vector_fetch
);
	localparam ST_RUN  = 4'h0;
	localparam ST_WAIT = 4'h1;
	localparam ST_STOP = 4'h2;
	localparam ST_SREC = 4'h3;
	localparam ST_POR  = 4'h4;
	localparam ST_DRV  = 4'h5;
	localparam ST_PIN  = 4'h6;
	localparam ST_HOLD = 4'h7;
	localparam ST_VEC  = 4'h8;

	reg  [3:0]  state_reg;
	reg  [3:0]  state_next;
	reg  [5:0]  seq_reg;
	reg  [5:0]  seq_next;
	reg  [12:0] sim_cnt_reg;
	reg         sim_clr_reg;
	reg         sim_clr_next;
	reg  [1:0]  div_reg;
	reg  [2:0]  cfg_reg;
	reg  [5:0]  cause_reg;
	reg  [5:0]  cause_set;
	reg  [5:0]  pin_low_reg;
	reg  [1:0]  pin_sync_reg;
	reg  [1:0]  wdog_sync_reg;
	reg  [1:0]  brown_sync_reg;
	reg         clk_cpu_on;
	reg         clk_per_on;
	reg         drv_en_reg;
	reg  [31:0] rd_data;
	reg         rd_err;
	wire        pin_low;
	wire        pin_rst;
	wire        ilad;
	wire        int_src;
	wire        in_reset;
	wire [12:0] stop_lim;
	wire        apb_wr;

	function [31:0] pad6;
		input [5:0] v;
		begin
			pad6 = {26'h000_0000, v};
		end
	endfunction

	// Only the second stage of each synchroniser is read
	assign pin_low  = ~pin_sync_reg[1];
	assign pin_rst  = cfg_reg[`SSC_CFG_PINEN] & (pin_low_reg >= `SSC_PIN_MIN_CYC);
	assign ilad     = opcode_fetch & unmapped_addr;
	assign int_src  = wdog_sync_reg[1] | illegal_opcode | ilad;
	assign in_reset = (state_reg == ST_POR) | (state_reg == ST_DRV) |
		(state_reg == ST_PIN) | (state_reg == ST_HOLD);
	assign stop_lim = cfg_reg[`SSC_CFG_SHORT_STOP_RECOVERY] ? `SSC_SHORT_STOP_CYC : `SSC_LONG_STOP_CYC;
	assign apb_wr   = psel & penable & pready & pwrite;

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pin_sync_reg   <= 2'h3;
			wdog_sync_reg  <= 2'h0;
			brown_sync_reg <= 2'h0;
		end else begin
			pin_sync_reg   <= {pin_sync_reg[0], reset_pin_in};
			wdog_sync_reg  <= {wdog_sync_reg[0], watchdog_req};
			brown_sync_reg <= {brown_sync_reg[0], brownout_detect};
		end
	end

	// Counter on the falling edge stops once bit 12, the thirteenth stage, is set
	always @(negedge sys_clk or posedge rst) begin
		if (rst)
			sim_cnt_reg <= 13'h0000;
		else if (sim_clr_reg)
			sim_cnt_reg <= 13'h0000;
		else if (!sim_cnt_reg[12])
			sim_cnt_reg <= sim_cnt_reg + 13'h0001;
	end

	// Low time is only counted while the pin is not driven by us
	always @(posedge sys_clk or posedge rst) begin
		if (rst)
			pin_low_reg <= 6'h00;
		else if (!pin_low || reset_pin_oe)
			pin_low_reg <= 6'h00;
		else if (pin_low_reg != 6'h3F)
			pin_low_reg <= pin_low_reg + 6'h01;
	end

	always @* begin
		state_next   = state_reg;
		seq_next     = seq_reg;
		sim_clr_next = 1'b0;
		cause_set    = 6'h00;
		if (brown_sync_reg[1] && state_reg != ST_POR) begin
			state_next = ST_POR;
			sim_clr_next = 1'b1;
			cause_set[`SSC_CAUSE_BROWN] = 1'b1;
		end else if (int_src && !in_reset && state_reg != ST_VEC) begin
			state_next = ST_DRV;
			seq_next = 6'h00;
			sim_clr_next = 1'b1;
			cause_set[`SSC_CAUSE_WDOG] = wdog_sync_reg[1];
			cause_set[`SSC_CAUSE_ILOP] = illegal_opcode;
			cause_set[`SSC_CAUSE_ILAD] = ilad;
		end else if (pin_rst && state_reg != ST_PIN && state_reg != ST_POR &&
			state_reg != ST_DRV) begin
			state_next = ST_PIN;
			cause_set[`SSC_CAUSE_PIN] = 1'b1;
		end else begin
			case (state_reg)
			ST_RUN: begin
				if (stop_req) begin
					state_next = ST_STOP;
					sim_clr_next = 1'b1;
				end else if (wait_req) begin
					state_next = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (wake_event)
					state_next = ST_RUN;
			end
			ST_STOP: begin
				sim_clr_next = 1'b1;
				if (wake_event) begin
					state_next = ST_SREC;
					sim_clr_next = 1'b0;
				end
			end
			ST_SREC: begin
				if (sim_cnt_reg >= stop_lim)
					state_next = ST_RUN;
			end
			ST_POR: begin
				if (brown_sync_reg[1])
					sim_clr_next = 1'b1;
				else if (sim_cnt_reg >= `SSC_POR_CYC) begin
					state_next = ST_DRV;
					seq_next = 6'h00;
				end
			end
			ST_DRV: begin
				seq_next = seq_reg + 6'h01;
				if (seq_next == `SSC_DRIVE_CYC) begin
					state_next = ST_HOLD;
					seq_next = 6'h00;
				end
			end
			ST_PIN: begin
				if (!pin_low) begin
					state_next = ST_HOLD;
					seq_next = 6'h00;
				end
			end
			ST_HOLD: begin
				seq_next = seq_reg + 6'h01;
				if (seq_next == `SSC_HOLD_CYC) begin
					state_next = ST_VEC;
					seq_next = 6'h00;
				end
			end
			ST_VEC: begin
				seq_next = seq_reg + 6'h01;
				if (seq_next == `SSC_VEC_CYC)
					state_next = ST_RUN;
			end
			default: state_next = ST_RUN;
			endcase
		end
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg   <= ST_POR;
			seq_reg     <= 6'h00;
			sim_clr_reg <= 1'b1;
		end else begin
			state_reg   <= state_next;
			seq_reg     <= seq_next;
			sim_clr_reg <= sim_clr_next;
		end
	end

	// Clock enables and divided clocks
	always @* begin
		clk_cpu_on = (state_reg == ST_RUN) | (state_reg == ST_VEC);
		clk_per_on = clk_cpu_on |
			((state_reg == ST_WAIT) & cfg_reg[`SSC_CFG_WAITPER]);
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			div_reg           <= 2'h0;
			half_source_clock <= 1'b0;
			cpu_bus_clk       <= 1'b0;
			periph_bus_clk    <= 1'b0;
			internal_reset    <= 1'b1;
			reset_pin_out     <= 1'b0;
			reset_pin_oe      <= 1'b0;
			port_a_bit_three  <= 1'b1;
			vector_addr       <= `SSC_VEC_USER;
			vector_fetch      <= 1'b0;
		end else begin
			div_reg           <= div_reg + 2'h1;
			half_source_clock <= ~div_reg[0];
			// Enables are taken only as a high phase starts, so no phase is cut short
			cpu_bus_clk       <= div_reg[0] ? (div_reg[1] & cpu_bus_clk) :
				(div_reg[1] & clk_cpu_on);
			periph_bus_clk    <= div_reg[0] ? (div_reg[1] & periph_bus_clk) :
				(div_reg[1] & clk_per_on);
			internal_reset    <= (state_next == ST_POR) | (state_next == ST_DRV) |
				(state_next == ST_PIN) | (state_next == ST_HOLD);
			reset_pin_out     <= 1'b0;
			// Pin drive only once the pin has its reset function
			reset_pin_oe      <= (state_next == ST_DRV) & drv_en_reg;
			port_a_bit_three  <= pin_sync_reg[1];
			vector_addr       <= monitor_mode ? `SSC_VEC_MON : `SSC_VEC_USER;
			vector_fetch      <= (state_next == ST_VEC);
		end
	end

	// Pin enable is frozen through a reset sequence, since the config is cleared inside it
	always @(posedge sys_clk or posedge rst) begin
		if (rst)
			drv_en_reg <= 1'b0;
		else if (!internal_reset)
			drv_en_reg <= cfg_reg[`SSC_CFG_PINEN];
	end

	// Registers: config returns to default while internal reset is asserted
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg_reg   <= `SSC_CFG_RST;
			cause_reg <= `SSC_CAUSE_RST;
		end else begin
			if (internal_reset && state_reg != ST_VEC)
				cfg_reg <= `SSC_CFG_RST;
			else if (apb_wr && paddr == `SSC_CFG_OFS)
				cfg_reg <= pwdata[2:0];
			// Write one to clear; a new cause in the same cycle wins
			if (apb_wr && paddr == `SSC_CAUSE_OFS)
				cause_reg <= (cause_reg & ~pwdata[5:0]) | cause_set;
			else
				cause_reg <= cause_reg | cause_set;
		end
	end

	always @* begin
		rd_data = 32'h0000_0000;
		rd_err  = 1'b0;
		case (paddr)
		`SSC_CFG_OFS:   rd_data = {29'h0000_0000, cfg_reg};
		`SSC_CAUSE_OFS: rd_data = pad6(cause_reg);
		`SSC_STAT_OFS:  rd_data = {15'h0000, sim_cnt_reg, state_reg};
		default:        rd_err  = 1'b1;
		endcase
	end

	// One wait state so read data comes from a flip-flop
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & rd_err;
			if (psel && penable && !pready)
				prdata <= pwrite ? 32'h0000_0000 : rd_data;
		end
	end
endmodule

// [ssc_top_properties.sv]
// Port assertions for the reset sequencer
`timescale 1ns/10ps
`include "ssc_regs.vh"
module ssc_props (
	input wire        sys_clk,
	input wire        rst,
	input wire        psel,
	input wire        penable,
	input wire [11:0] paddr,
	input wire        pready,
	input wire        pslverr,
	input wire        reset_pin_oe,
	input wire        internal_reset,
	input wire        cpu_bus_clk,
	input wire        periph_bus_clk,
	input wire [15:0] vector_addr,
	input wire        vector_fetch,
	input wire        monitor_mode,
	input wire        stop_req,
	input wire        wait_req
);
	logic [6:0] oe_cnt;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Length of the current drive-low run on the pin
	always @(posedge sys_clk or posedge rst)
		if (rst)
			oe_cnt <= 7'h00;
		else
			oe_cnt <= reset_pin_oe ? oe_cnt + 7'h01 : 7'h00;
	sequence s_hold;
		(internal_reset throughout (1'b1 ##31 1'b1)) ##1 !internal_reset;
	endsequence
	sequence s_vec;
		vector_fetch [*3] ##1 !vector_fetch;
	endsequence
	// Gating acts only between high phases, so every high phase lasts two cycles
	AST_DIV: assert property ($rose(periph_bus_clk) |=> periph_bus_clk ##1 !periph_bus_clk)
		else $error("bus clock not quarter rate");
	AST_CPUDIV: assert property ($rose(cpu_bus_clk) |=> cpu_bus_clk ##1 !cpu_bus_clk)
		else $error("cpu clock not quarter rate");
	AST_STOP: assert property (stop_req && !internal_reset && !vector_fetch |->
		##3 !cpu_bus_clk) else $error("cpu clock runs in stop");
	AST_DRIVE: assert property ($fell(reset_pin_oe) |-> oe_cnt == 7'h20)
		else $error("pin drive length wrong");
	AST_HOLD: assert property ($fell(reset_pin_oe) |-> s_hold)
		else $error("internal reset hold wrong");
	AST_VEC: assert property ($fell(internal_reset) |-> s_vec)
		else $error("vector phase wrong");
	AST_VADDR: assert property (vector_fetch && $stable(monitor_mode) |->
		vector_addr == (monitor_mode ? `SSC_VEC_MON : `SSC_VEC_USER)) else $error("vector wrong");
	AST_WAIT: assert property (wait_req [*4] |-> !cpu_bus_clk)
		else $error("cpu clock runs in wait");
	AST_APB: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("apb wait state wrong");
	AST_ERR: assert property (pready |-> pslverr == !(paddr inside
		{`SSC_CFG_OFS, `SSC_CAUSE_OFS, `SSC_STAT_OFS})) else $error("slave error wrong");
endmodule
bind ssc_top ssc_props u_props (.sys_clk, .rst, .psel, .penable, .paddr, .pready, .pslverr,
	.reset_pin_oe, .internal_reset, .cpu_bus_clk, .periph_bus_clk, .vector_addr, .vector_fetch,
	.monitor_mode, .stop_req, .wait_req);

// [ssc_peer.sv]
// Outside party sharing the open-drain reset pin
`timescale 1ns/10ps
module ssc_peer (
	input  wire  reset_pin_oe,
	input  wire  reset_pin_out,
	input  logic pull_low,
	output logic reset_pin_in
);
	// Pull-up wins only while nobody drives the wire low
	assign reset_pin_in = !(pull_low || (reset_pin_oe && !reset_pin_out));
endmodule

// [system_reset_clock_sequencer_test.sv]
// Self-checking bench for the reset sequencer
`timescale 1ns/10ps
`include "ssc_regs.vh"
module system_reset_clock_sequencer_test;
	logic        sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pull_low = 0, e;
	logic        watchdog_req = 0, brownout_detect = 0, illegal_opcode = 0, opcode_fetch = 0;
	logic        unmapped_addr = 0, monitor_mode = 0, stop_req = 0, wait_req = 0, wake_event = 0;
	logic        pready, pslverr, reset_pin_in, reset_pin_out, reset_pin_oe, port_a_bit_three;
	logic        internal_reset, half_source_clock, cpu_bus_clk, periph_bus_clk, vector_fetch;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, r, seed = 32'h0000_F3D0;
	logic [15:0] vector_addr;
	int          error_cnt = 0, n_tests = 0, cyc, k;
	int          pos[5] = '{`SSC_CAUSE_WDOG, `SSC_CAUSE_ILOP, `SSC_CAUSE_ILAD, 0, `SSC_CAUSE_BROWN};
	ssc_top uut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .reset_pin_in, .reset_pin_out, .reset_pin_oe, .port_a_bit_three, .watchdog_req,
		.brownout_detect, .illegal_opcode, .opcode_fetch, .unmapped_addr, .monitor_mode,
		.stop_req, .wait_req, .wake_event, .internal_reset, .half_source_clock, .cpu_bus_clk,
		.periph_bus_clk, .vector_addr, .vector_fetch);
	ssc_peer peer (.reset_pin_oe, .reset_pin_out, .pull_low, .reset_pin_in);
	initial forever #25 sys_clk = ~sys_clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_tests++;
		if (got !== ex) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic results;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) begin
			chk("apb_timeout", 0, 1);
			results();
		end
	endtask
	// Polls the reset or the bus clock; running out of patience ends the run
	task automatic wait_on(input logic sel, input logic lvl, input int max);
		cyc = 0;
		while ((sel ? periph_bus_clk : internal_reset) !== lvl && cyc < max) begin
			@(posedge sys_clk);
			cyc++;
		end
		if (cyc >= max) begin
			chk("wait_timeout", 0, 1);
			results();
		end
	endtask
	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		wait_on(0, 0, 5000);
		chk("por_len", 1, cyc >= 4096);
		apb(0, `SSC_CAUSE_OFS, 0);
		chk("cause_por", `SSC_CAUSE_RST, r);
		apb(0, 12'h00C, 0);
		chk("unmapped", 1, e);
		for (k = 0; k < 4; k++) begin
			seed = xs(seed);
			apb(1, `SSC_CFG_OFS, seed & 6);
			apb(0, `SSC_CFG_OFS, 0);
			chk("cfg", seed & 6, r);
		end
		// Sources in turn; the fourth is a data fetch from an unmapped place
		for (k = 0; k < 5; k++) begin
			seed = xs(seed);
			apb(1, `SSC_CFG_OFS, 1);
			apb(1, `SSC_CAUSE_OFS, 32'h0000_003F);
			monitor_mode <= seed[0];
			watchdog_req <= (k == 0);
			illegal_opcode <= (k == 1);
			opcode_fetch <= (k == 2);
			unmapped_addr <= (k == 2 || k == 3);
			brownout_detect <= (k == 4);
			repeat (3) @(posedge sys_clk);
			{watchdog_req, illegal_opcode, opcode_fetch, unmapped_addr, brownout_detect} <= 5'h00;
			repeat (8) @(posedge sys_clk);
			chk("reset_in", k != 3, internal_reset);
			chk("pin_drive", k < 3, reset_pin_oe);
			chk("pin_level", k >= 3, reset_pin_in);
			chk("pin_out", 0, reset_pin_out);
			wait_on(0, 0, 5000);
			chk("vector", monitor_mode ? `SSC_VEC_MON : `SSC_VEC_USER, vector_addr);
			apb(0, `SSC_CAUSE_OFS, 0);
			chk("cause", k == 3 ? 0 : 1 << pos[k], r);
			apb(0, `SSC_CFG_OFS, 0);
			chk("cfg_dflt", k == 3 ? 1 : 0, r);
			apb(0, `SSC_STAT_OFS, 0);
			chk("cnt_clr", k == 4, r[16]);
		end
		apb(1, `SSC_CFG_OFS, 0);
		pull_low <= 1'b1;
		repeat (10) @(posedge sys_clk);
		chk("pin_port", 0, port_a_bit_three);
		chk("pin_off", 0, internal_reset);
		pull_low <= 1'b0;
		apb(1, `SSC_CFG_OFS, 1);
		apb(1, `SSC_CAUSE_OFS, 32'h0000_003F);
		pull_low <= 1'b1;
		repeat (2) @(posedge sys_clk);
		pull_low <= 1'b0;
		repeat (6) @(posedge sys_clk);
		chk("pin_short", 0, internal_reset);
		pull_low <= 1'b1;
		repeat (10) @(posedge sys_clk);
		chk("pin_halt", 1, internal_reset);
		pull_low <= 1'b0;
		wait_on(0, 0, 500);
		apb(0, `SSC_CAUSE_OFS, 0);
		chk("cause_pin", 32'h0000_0002, r);
		apb(0, `SSC_STAT_OFS, 0);
		chk("cnt_keep", 1, r[16]);
		r = half_source_clock;
		@(posedge sys_clk);
		chk("half_clk", !r[0], half_source_clock);
		// Wait mode with the peripheral clock off, then on
		for (k = 0; k < 2; k++) begin
			apb(1, `SSC_CFG_OFS, k << 2);
			wait_req <= 1'b1;
			repeat (8) @(posedge sys_clk);
			chk("wait_cpu", 0, cpu_bus_clk);
			r = 0;
			repeat (4) begin
				@(posedge sys_clk);
				r = r | periph_bus_clk;
			end
			chk("wait_per", k, r);
			wait_req <= 1'b0;
			wake_event <= 1'b1;
			@(posedge sys_clk);
			wake_event <= 1'b0;
		end
		// Short then full stop recovery
		for (k = 0; k < 2; k++) begin
			apb(1, `SSC_CFG_OFS, k ? 0 : 2);
			stop_req <= 1'b1;
			@(posedge sys_clk);
			stop_req <= 1'b0;
			repeat (40) @(posedge sys_clk);
			chk("stop_off", 0, periph_bus_clk);
			wake_event <= 1'b1;
			@(posedge sys_clk);
			wake_event <= 1'b0;
			wait_on(1, 1, 5000);
			chk("stop_rec", 1, k ? (cyc >= 4096 && cyc < 4110) : (cyc >= 28 && cyc < 40));
		end
		results();
	end
endmodule
